// >>> apis_lpf.sv
// apis_lpf: first-order low-pass filter stepped once per millisecond tick
// assumes tick is a one-cycle pulse; time constant zero passes x straight through
`timescale 1ns/1ns
module apis_lpf (
  input wire logic clock,
  input wire logic nrst,
  input wire logic tick,
  input wire logic [apis_pkg::TIME_W-1:0] time_ms,
  input wire logic [apis_pkg::FLT_W-1:0] x,
  output logic [apis_pkg::FLT_W-1:0] y
);
  import apis_pkg::*;

  typedef struct packed {
    logic [FLT_W+FRAC_W-1:0] acc;
  } apis_lpf_s;

  apis_lpf_s q;
  apis_lpf_s d;
  logic [FLT_W+FRAC_W-1:0] rnd;

  always_comb begin
    int diff;
    diff = 0;
    d = q;
    if (time_ms == '0) begin
      d.acc = {x, FRAC_W'(0)};
    end else if (tick) begin
      // wide fraction keeps the truncation error below one output step
      diff = int'({x, FRAC_W'(0)}) - int'(q.acc);
      d.acc = (FLT_W+FRAC_W)'(int'(q.acc) + diff / (int'(time_ms) + 1));
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // round on the way out: from below the acc stops a fraction of a step short of x
  assign rnd = q.acc + {FLT_W'(0), 1'b1, (FRAC_W-1)'(0)};
  assign y = rnd[FLT_W+FRAC_W-1:FRAC_W];

endmodule : apis_lpf

// >>> apis_pkg.sv
// apis_pkg: constants and types of the pulse and analog input scaling block
// assumes one 250 MHz clock; frequency in 10 Hz, voltage in 10 mV, percent in 0.1 %
package apis_pkg;

  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int GATE_MS = 100;
  localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;

  localparam int TICK_W = 18;
  localparam int GATE_W = 25;
  localparam int EDGE_W = 16;
  localparam int FREQ_W = 13;
  localparam int PCT_W = 12;
  localparam int VOLT_W = 11;
  localparam int RAW_W = 12;
  localparam int TIME_W = 14;
  localparam int FLT_W = 16;
  localparam int FRAC_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCH = 4;
  localparam int NPT = 4;
  localparam int OPT_FIRST = 2;

  localparam int FREQ_MAX = 5000;
  localparam int VOLT_MAX = 1000;
  localparam int PCT_MAX = 1000;
  localparam int TIME_MAX = 10000;

  localparam logic [FREQ_W-1:0] PMIN_F_RST = 13'h0064;
  localparam logic [FREQ_W-1:0] PMAX_F_RST = 13'h0bb8;
  localparam logic [PCT_W-1:0] PMIN_S_RST = 12'h000;
  localparam logic [PCT_W-1:0] PMAX_S_RST = 12'h3e8;
  localparam logic [TIME_W-1:0] PFLT_RST = 14'h0032;
  localparam logic [TIME_W-1:0] AFLT_RST = 14'h0064;
  localparam logic [NCH-1:0][7:0] SEL_RST = 32'h03020100;
  localparam logic [7:0] SEL_MASK = 8'h13;
  localparam int SEL_TENS = 4;

  localparam logic [NPT-1:0][VOLT_W-1:0] PT2_X = {11'h000, 11'h000, 11'h3e8, 11'h000};
  localparam logic [NPT-1:0][VOLT_W-1:0] PT4_X = {11'h3e8, 11'h258, 11'h12c, 11'h000};
  localparam logic [NPT-1:0][PCT_W-1:0] PT2_Y = {12'h000, 12'h000, 12'h3e8, 12'h000};
  localparam logic [NPT-1:0][PCT_W-1:0] PT4_Y = {12'h3e8, 12'h258, 12'h12c, 12'h000};

  // register map: bases and strides in bytes, register numbers in words
  localparam int WORD = 4;
  localparam int P_MINF = 0;
  localparam int P_MAXF = 1;
  localparam int P_MINS = 2;
  localparam int P_MAXS = 3;
  localparam int P_FLT = 4;
  localparam int P_MEAS = 5;
  localparam int P_EQ = 6;
  localparam int P_MODE = 7;
  localparam int CH_BASE = 32;
  localparam int CH_STRIDE = 16;
  localparam int CH_SEL = 0;
  localparam int CH_FLT = 1;
  localparam int CH_ACT = 2;
  localparam int CH_CONV = 3;
  localparam int CRV_BASE = 96;
  localparam int CRV_STRIDE = 32;
  localparam int PT_STRIDE = 8;
  localparam int CRV_END = 224;

  typedef enum logic [1:0] {
    CURVE_A = 2'b00,
    CURVE_B = 2'b01,
    CURVE_C = 2'b10,
    CURVE_D = 2'b11
  } apis_curve_e;

  typedef enum logic {
    BELOW_HOLD = 1'b0,
    BELOW_ZERO = 1'b1
  } apis_below_e;

endpackage : apis_pkg

// >>> apis_scale.sv
// apis_scale: pulse frequency and four analog inputs, filtered and mapped to percent
// assumes an APB master on clock, inputs synchronous to clock, adc codes per channel
//
// Notes on behaviour
// - pulse min/max frequency map to min/max settings
// - pulse frequency measured 0..50 kHz, 10 Hz steps
// - pulse filter 0..10 s, default 50 ms
// - pulse equivalent value readable, -100..100 %
// - curve units digit picks curve A..D
// - tens digit: below minimum hold or zero
// - curve settings reset to 00, 01, 02, 03
// - analog filters 0..10 s, default 100 ms
// - port voltage readable, 0..10 V, 10 mV
// - current input reports half the milliamperes
// - selected curve output readable as conversion value
// - channels three and four need option card
// - curves A, B two points; C, D four
`timescale 1ns/1ns
module apis_scale #(
  parameter int TICK_CYC = apis_pkg::TICK_CYCLES,
  parameter int GATE_CYC = apis_pkg::GATE_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [apis_pkg::ADDR_W-1:0] paddr,
  input wire logic [apis_pkg::DATA_W-1:0] pwdata,
  output logic [apis_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_pulse_input,
  input wire logic [apis_pkg::RAW_W-1:0] analog_channel_1,
  input wire logic [apis_pkg::RAW_W-1:0] analog_channel_2,
  input wire logic [apis_pkg::RAW_W-1:0] analog_channel_3,
  input wire logic [apis_pkg::RAW_W-1:0] analog_channel_4,
  input wire logic option_card_present,
  output logic [apis_pkg::PCT_W-1:0] pulse_equivalent_value,
  output logic [apis_pkg::PCT_W-1:0] analog_conversion_1,
  output logic [apis_pkg::PCT_W-1:0] analog_conversion_2,
  output logic [apis_pkg::PCT_W-1:0] analog_conversion_3,
  output logic [apis_pkg::PCT_W-1:0] analog_conversion_4
);
  import apis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////

  typedef logic [NCH-1:0][NPT-1:0][VOLT_W-1:0] apis_cx_t;
  typedef logic [NCH-1:0][NPT-1:0][PCT_W-1:0] apis_cy_t;

  typedef struct packed {
    logic [FREQ_W-1:0] pmin_f;
    logic [FREQ_W-1:0] pmax_f;
    logic [PCT_W-1:0] pmin_s;
    logic [PCT_W-1:0] pmax_s;
    logic [TIME_W-1:0] pflt;
    logic [NCH-1:0] cur_mode;
    logic [NCH-1:0][7:0] sel;
    logic [NCH-1:0][TIME_W-1:0] aflt;
    apis_cx_t cx;
    apis_cy_t cy;
    logic pin_prev;
    logic [EDGE_W-1:0] edges;
    logic [GATE_W-1:0] gate;
    logic [FREQ_W-1:0] meas_f;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [PCT_W-1:0] pulse_eq;
    logic [NCH-1:0][VOLT_W-1:0] ain;
    logic [NCH-1:0][PCT_W-1:0] conv;
    logic [DATA_W-1:0] prdata;
    logic slverr;
  } apis_state_s;

  apis_state_s q;
  apis_state_s d;

  logic [FLT_W-1:0] pflt_y;
  logic [NCH-1:0][FLT_W-1:0] aflt_y;
  logic [NCH-1:0][RAW_W-1:0] ain_raw;

  assign ain_raw = {analog_channel_4, analog_channel_3, analog_channel_2, analog_channel_1};

  ////////////////////////////////////////////////////////////////////////////////

  function automatic int satu(int v, int vmax);
    if (v < 0) begin
      return 0;
    end
    return (v > vmax) ? vmax : v;
  endfunction : satu

  function automatic int sats(int v);
    if (v < -PCT_MAX) begin
      return -PCT_MAX;
    end
    return (v > PCT_MAX) ? PCT_MAX : v;
  endfunction : sats

  function automatic int spct(logic [PCT_W-1:0] v);
    return int'($signed(v));
  endfunction : spct

  // caller keeps x0 <= x <= x1; a flat segment takes its upper point
  function automatic logic [PCT_W-1:0] lerp(int x, int x0, int x1, int y0, int y1);
    int r;
    if (x1 <= x0) begin
      r = y1;
    end else begin
      r = y0 + (x - x0) * (y1 - y0) / (x1 - x0);
    end
    return PCT_W'(r);
  endfunction : lerp

  function automatic logic [PCT_W-1:0] map_curve(int v, logic [7:0] sel,
                                                 apis_cx_t cx, apis_cy_t cy);
    apis_curve_e c;
    apis_below_e below;
    int last;
    logic [PCT_W-1:0] r;
    c = apis_curve_e'(2'(sel));
    below = apis_below_e'(sel[SEL_TENS]);
    last = (c == CURVE_A || c == CURVE_B) ? 1 : NPT - 1;
    if (v < int'(cx[c][0])) begin
      r = (below == BELOW_ZERO) ? '0 : cy[c][0];
    end else begin
      r = cy[c][last];
      // scan downward so the lowest segment holding v wins
      for (int i = NPT - 1; i >= 1; i--) begin
        if (i <= last && v <= int'(cx[c][i])) begin
          r = lerp(v, int'(cx[c][i-1]), int'(cx[c][i]), spct(cy[c][i-1]), spct(cy[c][i]));
        end
      end
    end
    return r;
  endfunction : map_curve

  function automatic logic [PCT_W-1:0] map_pulse(int f, apis_state_s s);
    int lo;
    int hi;
    lo = int'(s.pmin_f);
    hi = int'(s.pmax_f);
    if (f <= lo) begin
      return s.pmin_s;
    end
    if (f >= hi) begin
      return s.pmax_s;
    end
    return lerp(f, lo, hi, spct(s.pmin_s), spct(s.pmax_s));
  endfunction : map_pulse

  ////////////////////////////////////////////////////////////////////////////////

  apis_lpf u_pulse_lpf (
    .clock(clock),
    .nrst(nrst),
    .tick(q.tick),
    .time_ms(q.pflt),
    .x(FLT_W'(q.meas_f)),
    .y(pflt_y)
  );

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    apis_lpf u_lpf (
      .clock(clock),
      .nrst(nrst),
      .tick(q.tick),
      .time_ms(q.aflt[g]),
      .x(FLT_W'(q.ain[g])),
      .y(aflt_y[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    int a;
    int ch;
    int rg;
    int crv;
    int pt;
    int isy;
    int wv;
    int cv;
    logic absent;
    logic err;
    logic [DATA_W-1:0] rd;
    a = int'(paddr);
    ch = 0;
    rg = 0;
    crv = 0;
    pt = 0;
    isy = 0;
    wv = int'($signed(pwdata));
    cv = 0;
    absent = 1'b0;
    err = 1'b0;
    rd = '0;
    d = q;

    // millisecond tick for the filters
    // one shared tick keeps every filter on the same time base
    d.tick = 1'b0;
    if (q.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 1'b1;
    end

    // edges in a 100 ms gate give the frequency in 10 Hz steps
    d.pin_prev = fast_pulse_input;
    if (fast_pulse_input && !q.pin_prev && q.edges != '1) begin
      d.edges = q.edges + 1'b1;
    end
    if (q.gate == GATE_W'(GATE_CYC - 1)) begin
      d.gate = '0;
      d.meas_f = FREQ_W'(satu(int'(d.edges), FREQ_MAX));
      d.edges = '0;
    end else begin
      d.gate = q.gate + 1'b1;
    end

    // mapping reads the filtered value, one clock behind the filter
    d.pulse_eq = map_pulse(int'(pflt_y), q);

    for (int i = 0; i < NCH; i++) begin
      // absent channels feed zero so their filters drain while the card is out
      absent = (i >= OPT_FIRST) && !option_card_present;
      cv = q.cur_mode[i] ? int'(ain_raw[i]) / 2 : int'(ain_raw[i]);
      d.ain[i] = absent ? '0 : VOLT_W'(satu(cv, VOLT_MAX));
      if (absent) begin
        d.conv[i] = '0;
      end else begin
        d.conv[i] = map_curve(int'(aflt_y[i]), q.sel[i], q.cx, q.cy);
      end
    end

    // address decode, shared by both phases since paddr is held
    if (a < CH_BASE) begin
      case (a / WORD)
        P_MINF: rd = DATA_W'(q.pmin_f);
        P_MAXF: rd = DATA_W'(q.pmax_f);
        P_MINS: rd = DATA_W'($signed(q.pmin_s));
        P_MAXS: rd = DATA_W'($signed(q.pmax_s));
        P_FLT: rd = DATA_W'(q.pflt);
        P_MEAS: rd = DATA_W'(pflt_y);
        P_EQ: rd = DATA_W'($signed(q.pulse_eq));
        P_MODE: rd = DATA_W'(q.cur_mode);
        default: rd = '0;
      endcase
    end else if (a < CRV_BASE) begin
      ch = (a - CH_BASE) / CH_STRIDE;
      rg = ((a - CH_BASE) % CH_STRIDE) / WORD;
      err = (ch >= OPT_FIRST) && !option_card_present;
      case (rg)
        CH_SEL: rd = DATA_W'(q.sel[ch]);
        CH_FLT: rd = DATA_W'(q.aflt[ch]);
        CH_ACT: rd = DATA_W'(aflt_y[ch]);
        CH_CONV: rd = DATA_W'($signed(q.conv[ch]));
        default: rd = '0;
      endcase
      if (err) begin
        rd = '0;
      end
    end else if (a < CRV_END) begin
      crv = (a - CRV_BASE) / CRV_STRIDE;
      pt = ((a - CRV_BASE) % CRV_STRIDE) / PT_STRIDE;
      isy = ((a - CRV_BASE) % PT_STRIDE) / WORD;
      rd = isy != 0 ? DATA_W'($signed(q.cy[crv][pt])) : DATA_W'(q.cx[crv][pt]);
    end else begin
      err = 1'b1;
    end

    // setup phase latches the answer so prdata comes from a flop
    if (psel && !penable) begin
      d.prdata = rd;
      d.slverr = err;
    end

    // refusal rides on the flag latched at setup, so a card change
    // between the two phases cannot split the answer from the write
    if (psel && penable && pwrite && !q.slverr) begin
      if (a < CH_BASE) begin
        case (a / WORD)
          P_MINF: d.pmin_f = FREQ_W'(satu(wv, FREQ_MAX));
          P_MAXF: d.pmax_f = FREQ_W'(satu(wv, FREQ_MAX));
          P_MINS: d.pmin_s = PCT_W'(sats(wv));
          P_MAXS: d.pmax_s = PCT_W'(sats(wv));
          P_FLT: d.pflt = TIME_W'(satu(wv, TIME_MAX));
          P_MODE: d.cur_mode = NCH'(pwdata);
          default: d.pflt = q.pflt;
        endcase
      end else if (a < CRV_BASE) begin
        case (rg)
          CH_SEL: d.sel[ch] = 8'(pwdata) & SEL_MASK;
          CH_FLT: d.aflt[ch] = TIME_W'(satu(wv, TIME_MAX));
          default: d.aflt[ch] = q.aflt[ch];
        endcase
      end else if (isy != 0) begin
        d.cy[crv][pt] = PCT_W'(sats(wv));
      end else begin
        d.cx[crv][pt] = VOLT_W'(satu(wv, VOLT_MAX));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= '0;
      q.pmin_f <= PMIN_F_RST;
      q.pmax_f <= PMAX_F_RST;
      q.pmin_s <= PMIN_S_RST;
      q.pmax_s <= PMAX_S_RST;
      q.pflt <= PFLT_RST;
      q.sel <= SEL_RST;
      q.aflt <= {NCH{AFLT_RST}};
      q.cx <= {PT4_X, PT4_X, PT2_X, PT2_X};
      q.cy <= {PT4_Y, PT4_Y, PT2_Y, PT2_Y};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // zero-wait slave: every access ends in its first access cycle
  // prdata was latched at setup, so the access cycle never waits on decode
  assign pready = psel & penable;
  assign prdata = q.prdata;
  assign pslverr = q.slverr;

  assign pulse_equivalent_value = q.pulse_eq;
  assign analog_conversion_1 = q.conv[0];
  assign analog_conversion_2 = q.conv[1];
  assign analog_conversion_3 = q.conv[2];
  assign analog_conversion_4 = q.conv[3];

endmodule : apis_scale

// >>> apis_scale_props.sv
// apis_scale_props: port-level checks of the scaling block
// assumes binding onto apis_scale; apb slave answers with no wait state
`timescale 1ns/1ns
module apis_scale_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [apis_pkg::ADDR_W-1:0] paddr,
  input wire logic [apis_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic option_card_present,
  input wire logic [apis_pkg::PCT_W-1:0] pulse_equivalent_value,
  input wire logic [apis_pkg::PCT_W-1:0] analog_conversion_1,
  input wire logic [apis_pkg::PCT_W-1:0] analog_conversion_3,
  input wire logic [apis_pkg::PCT_W-1:0] analog_conversion_4
);
  import apis_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready differs from access phase");
  a_reset_bus: assert property ($rose(nrst) |-> prdata == '0 && !pslverr)
    else $error("bus outputs not cleared by reset");
  a_reset_outputs: assert property ($rose(nrst) |-> pulse_equivalent_value == '0
    && analog_conversion_1 == '0) else $error("mapped outputs not cleared by reset");
  a_pulse_range: assert property ($signed(pulse_equivalent_value) >= -PCT_MAX
    && $signed(pulse_equivalent_value) <= PCT_MAX) else $error("pulse value out of range");
  a_conv_range: assert property ($signed(analog_conversion_1) >= -PCT_MAX
    && $signed(analog_conversion_1) <= PCT_MAX) else $error("conversion out of range");
  a_absent_three: assert property ((!option_card_present)[*3] |->
    analog_conversion_3 == '0) else $error("channel three active without card");
  a_absent_four: assert property ((!option_card_present)[*3] |->
    analog_conversion_4 == '0) else $error("channel four active without card");
  a_absent_regs: assert property (psel && !penable && paddr[7:5] == 3'h2
    && !option_card_present |=> pslverr && prdata == '0) else $error("card regs not refused");
  a_unmapped_err: assert property (psel && !penable && paddr >= 8'he0 |=> pslverr)
    else $error("unmapped address accepted");
  c_write: cover property (psel && penable && pwrite);
  c_refused: cover property (psel && penable && pslverr);
  c_negative: cover property ($signed(pulse_equivalent_value) < 0);
endmodule : apis_scale_props

bind apis_scale apis_scale_props apis_scale_props_i (.clock, .nrst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .option_card_present, .pulse_equivalent_value,
  .analog_conversion_1, .analog_conversion_3, .analog_conversion_4);

// >>> apis_src.sv
// apis_src: pulse generator and adc codes standing in front of the block
// assumes period in clock cycles, zero keeps the pulse line low
`timescale 1ns/1ns
module apis_src (
  input wire logic clock,
  input wire logic [15:0] period,
  input wire logic [apis_pkg::NCH-1:0][apis_pkg::RAW_W-1:0] codes,
  output logic fast_pulse_input,
  output logic [apis_pkg::RAW_W-1:0] analog_channel_1,
  output logic [apis_pkg::RAW_W-1:0] analog_channel_2,
  output logic [apis_pkg::RAW_W-1:0] analog_channel_3,
  output logic [apis_pkg::RAW_W-1:0] analog_channel_4
);
  logic [15:0] cnt = '0;
  logic lvl = 1'b0;
  // period dividing the gate gives the same edge count in every window
  always @(posedge clock) begin
    cnt <= (cnt + 16'h1 >= period) ? 16'h0 : cnt + 16'h1;
    lvl <= (period != 16'h0) && (cnt < period / 2);
  end
  assign fast_pulse_input = lvl;
  assign analog_channel_1 = codes[0];
  assign analog_channel_2 = codes[1];
  assign analog_channel_3 = codes[2];
  assign analog_channel_4 = codes[3];
endmodule : apis_src

// >>> test_analog_pulse_input_scaling.sv
// test_analog_pulse_input_scaling: self-checking bench of the scaling block
// assumes tick of 4 and gate of 1000 cycles; frequency reads as edges per gate
`timescale 1ns/1ns
module test_analog_pulse_input_scaling;
  import apis_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, rdat;
  logic pready, pslverr, err, fast_pulse_input;
  logic option_card_present = 1'b1;
  logic [15:0] period = '0;
  logic [NCH-1:0][RAW_W-1:0] codes = '0;
  logic [RAW_W-1:0] ach1, ach2, ach3, ach4;
  logic [PCT_W-1:0] peq, conv1, conv2, conv3, conv4;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  apis_src apis_src_i (.clock, .period, .codes, .fast_pulse_input, .analog_channel_1(ach1),
    .analog_channel_2(ach2), .analog_channel_3(ach3), .analog_channel_4(ach4));
  apis_scale #(.TICK_CYC(4), .GATE_CYC(1000)) apis_scale_i (.clock, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fast_pulse_input,
    .analog_channel_1(ach1), .analog_channel_2(ach2), .analog_channel_3(ach3),
    .analog_channel_4(ach4), .option_card_present, .pulse_equivalent_value(peq),
    .analog_conversion_1(conv1), .analog_conversion_2(conv2), .analog_conversion_3(conv3),
    .analog_conversion_4(conv4));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input int exp);
    checks_done++;
    if (got !== 32'(exp)) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, 32'(exp));
    end
  endtask : chk
  task automatic chk_pct(input logic [PCT_W-1:0] got, input int exp);
    chk({{20{got[PCT_W-1]}}, got}, exp);
  endtask : chk_pct
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d));
  endtask : wr
  task automatic rd(input logic [7:0] a, input int exp);
    apb(1'b0, a, '0);
    chk(rdat, exp);
  endtask : rd
  // zero filter time passes x on the next clock without waiting for a tick; output register adds one clock
  task automatic settle;
    repeat (24) @(posedge clock);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    for (int c = 0; c < NCH; c++) begin
      rd(8'(8'h20 + 8'h10 * c), c);
      rd(8'(8'h24 + 8'h10 * c), 100);
    end
    rd(8'h10, 50);
    rd(8'h00, 100);
    rd(8'h04, 3000);
    rd(8'h0c, 1000);
  endtask : t_defaults
  task automatic t_curves;
    wr(8'h24, 0);
    codes[0] <= 12'h3e8;
    for (int k = 0; k < 4; k++) begin
      wr(8'(8'h64 + 8'h20 * k + (k < 2 ? 8'h08 : 8'h18)), 100 * (k + 1));
      wr(8'h20, k);
      settle();
      chk_pct(conv1, 100 * (k + 1));
    end
    codes[0] <= 12'h1f4;
    settle();
    chk_pct(conv1, 500);
    wr(8'h20, 0);
    settle();
    chk_pct(conv1, 50);
  endtask : t_curves
  task automatic t_below;
    wr(8'h60, 200);
    wr(8'h64, 300);
    wr(8'h20, 0);
    codes[0] <= 12'h064;
    settle();
    chk_pct(conv1, 300);
    wr(8'h20, 8'h10);
    settle();
    chk_pct(conv1, 0);
    codes[0] <= 12'h258;
    settle();
    chk_pct(conv1, 200);
    rd(8'h2c, 200);
  endtask : t_below
  task automatic t_volts;
    wr(8'h34, 0);
    codes[1] <= 12'h1f4;
    settle();
    rd(8'h38, 500);
    chk_pct(conv2, 100);
    codes[1] <= 12'hbb8;
    settle();
    rd(8'h38, 1000);
    wr(8'h1c, 2);
    codes[1] <= 12'h640;
    settle();
    rd(8'h38, 800);
    wr(8'h1c, 0);
  endtask : t_volts
  task automatic t_option;
    wr(8'h44, 0);
    wr(8'h54, 0);
    codes[2] <= 12'h1f4;
    codes[3] <= 12'h1f4;
    settle();
    chk_pct(conv3, 500);
    chk_pct(conv4, 500);
    option_card_present <= 1'b0;
    settle();
    chk_pct(conv3, 0);
    chk_pct(conv4, 0);
    rd(8'h40, 0);
    chk({31'h0, err}, 1);
    rd(8'h5c, 0);
    chk({31'h0, err}, 1);
    option_card_present <= 1'b1;
    rd(8'h40, 2);
    rd(8'h50, 3);
    chk({31'h0, err}, 0);
    rd(8'he4, 0);
    chk({31'h0, err}, 1);
  endtask : t_option
  task automatic t_pulse;
    int per[3] = '{100, 40, 20};
    int frq[3] = '{10, 25, 50};
    int pct[3] = '{-500, -125, 500};
    wr(8'h10, 0);
    wr(8'h00, 10);
    wr(8'h04, 50);
    wr(8'h08, -500);
    wr(8'h0c, 500);
    for (int i = 0; i < 3; i++) begin
      period <= 16'(per[i]);
      repeat (3100) @(posedge clock);
      rd(8'h14, frq[i]);
      rd(8'h18, pct[i]);
      chk_pct(peq, pct[i]);
    end
  endtask : t_pulse
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    t_defaults();
    t_curves();
    t_below();
    t_volts();
    t_option();
    t_pulse();
    print_verdict();
  end
endmodule : test_analog_pulse_input_scaling
